// ==== hw/hilo_multiply_subtract_unit.sv ====
// hilo_multiply_subtract_unit: high/low result pair with multiply-subtract and moves.
// assumes the pipeline presents one decoded word with operands and holds it while busy is high.
//
// Overview of operation
// RL1: signed multiply-subtract multiplies the low 32-bit words as signed values into a 64-bit product.
// RL2: the product is subtracted from the low 32 bits of high concatenated above the low 32 bits of low.
// RL3: upper and lower 32 bits of the difference are sign-extended into the high and low registers.
// RL4: multiply-subtract never raises an arithmetic or overflow exception.
// RL5: unsigned multiply-subtract zero-extends both 32-bit words, then works as the signed one.
// RL6: the issuer supplies operands with bits 63 to 31 equal, otherwise the result is arbitrary.
// RL7: multiply-subtract writes only the high/low pair, never a general register.
// RL8: unsigned multiply-subtract decodes from major opcode 011100, function 000101, bits 15..6 zero.
// RL9: signed multiply-subtract decodes from the same opcode, function 000100, bits 15..6 zero.
// RL10: move-to-high copies the full source into high and leaves low unchanged.
// RL11: move-to-low copies the full source into low.
// RL12: software reads the pair after a multiply or divide before writing either half again.
// RL13: move-to-high after an unread multiply/divide result may leave low with any value.
// RL14: move-to-low after an unread multiply/divide result may leave high with any value.
// RL15: no minimum separation between a result read and a later write of high or low.
// RL16: software should put the shorter operand in the second source register.
// RL17: while a multiply-subtract is pending, reads of high or low are stalled.
`default_nettype none
module hilo_multiply_subtract_unit
  import hilo_mul_sub_signed_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic instrValid,
  input wire logic [hilo_mul_sub_signed_pkg::InstrWidth-1:0] instrWord,
  input wire logic [hilo_mul_sub_signed_pkg::DataWidth-1:0] sourceOperandA,
  input wire logic [hilo_mul_sub_signed_pkg::DataWidth-1:0] sourceOperandB,
  input wire logic readHighReq,
  input wire logic readLowReq,
  output logic busy,
  output logic readStall,
  output logic arithException,
  output logic gprWriteEn,
  output logic [hilo_mul_sub_signed_pkg::DataWidth-1:0] highResult,
  output logic [hilo_mul_sub_signed_pkg::DataWidth-1:0] lowResult
);
  import hilo_mul_sub_signed_pkg::*;

  mul_sub_signed_state_type state_q;
  logic [63:0] highResult_q;
  logic [63:0] lowResult_q;
  logic [63:0] product_q;
  logic [63:0] accum_q;
  logic [63:0] diff;
  logic [5:0] opcode;
  logic [5:0] func;
  logic zeroField;
  logic isMulSubSigned;
  logic isMulSubUnsigned;
  logic isMoveHigh;
  logic isMoveLow;
  logic accept;
  logic [63:0] extA;
  logic [63:0] extB;

  assign opcode = instrWord[InstrWidth-1:OpcodeLsb];
  assign func = instrWord[5:0];
  assign zeroField = (instrWord[ZeroFieldMsb:ZeroFieldLsb] == 10'h000);
  assign isMulSubUnsigned = (opcode == OpcodeGroupTwo) && (func == FuncMulSubUnsigned) && zeroField; // [RL8]
  assign isMulSubSigned = (opcode == OpcodeGroupTwo) && (func == FuncMulSubSigned) && zeroField; // [RL9]
  // moves carry zeros in bits 20..6
  assign isMoveHigh = (opcode == OpcodeSpecial) && (func == FuncMoveToHigh)
                      && (instrWord[MoveZeroMsb:ZeroFieldLsb] == 15'h0000);
  assign isMoveLow = (opcode == OpcodeSpecial) && (func == FuncMoveToLow)
                     && (instrWord[MoveZeroMsb:ZeroFieldLsb] == 15'h0000);

  // busy spans both stages; the issuer holds its word until busy drops
  assign busy = (state_q != IDLE);
  // a word seen while busy is simply not taken, so it needs no flush logic
  assign accept = instrValid && !busy;
  // reads are held off rather than served stale, at the cost of a two-cycle bubble
  assign readStall = busy && (readHighReq || readLowReq); // [RL17]
  assign arithException = 1'b0; // [RL4]
  assign gprWriteEn = 1'b0; // [RL7]
  assign highResult = highResult_q;
  assign lowResult = lowResult_q;

  // only low words matter; upper bits are assumed a copy of bit 31 [RL6]
  assign extA = isMulSubSigned ? {{32{sourceOperandA[31]}}, sourceOperandA[31:0]}
                               : {32'h0000_0000, sourceOperandA[31:0]}; // [RL1] [RL5]
  assign extB = isMulSubSigned ? {{32{sourceOperandB[31]}}, sourceOperandB[31:0]}
                               : {32'h0000_0000, sourceOperandB[31:0]}; // [RL1] [RL5]
  // wraps modulo 2^64, no overflow flag
  assign diff = accum_q - product_q; // [RL2] [RL4]

  // two stages: product then subtract, keeps the multiplier off the adder path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IDLE;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (accept && (isMulSubSigned || isMulSubUnsigned)) begin
            state_q <= MULT;
          end
        end
        MULT: begin
          state_q <= SUBT;
        end
        SUBT: begin
          state_q <= IDLE;
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      product_q <= HiloReset;
      accum_q <= HiloReset;
    end else if (accept && (isMulSubSigned || isMulSubUnsigned)) begin
      product_q <= extA * extB; // [RL1] [RL5]
      accum_q <= {highResult_q[31:0], lowResult_q[31:0]}; // [RL2]
    end
  end

  // moves keep the other half as is, a legal outcome of the unread-result cases [RL13] [RL14]
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      highResult_q <= HiloReset;
      lowResult_q <= HiloReset;
    end else if (state_q == SUBT) begin
      highResult_q <= {{32{diff[63]}}, diff[63:32]}; // [RL3]
      lowResult_q <= {{32{diff[31]}}, diff[31:0]}; // [RL3]
    end else if (accept && isMoveHigh) begin
      highResult_q <= sourceOperandA; // [RL10] [RL15]
    end else if (accept && isMoveLow) begin
      lowResult_q <= sourceOperandA; // [RL11] [RL15]
    end
  end

  a_signed_result: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL1]
    (accept && isMulSubSigned && highResult_q == 64'h0 && lowResult_q == 64'h0
     && sourceOperandA[31:0] == 32'hffff_ffff && sourceOperandB[31:0] == 32'h0000_0002)
    |-> ##3 (lowResult_q == 64'h0000_0000_0000_0002 && highResult_q == 64'h0))
    else $error("signed multiply-subtract result wrong");
  a_sub_pair: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL2]
    (state_q == SUBT) |=> ({highResult_q[31:0], lowResult_q[31:0]} == $past(accum_q) - $past(product_q)))
    else $error("difference not written to pair");
  a_sign_extend: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL3]
    $past(state_q == SUBT) |-> (highResult_q[63:32] == {32{highResult_q[31]}}
                                && lowResult_q[63:32] == {32{lowResult_q[31]}}))
    else $error("result halves not sign-extended");
  a_no_exception: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL4]
    busy |-> !arithException)
    else $error("exception raised by multiply-subtract");
  a_unsigned_result: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL5]
    (accept && isMulSubUnsigned && highResult_q == 64'h0 && lowResult_q == 64'h0
     && sourceOperandA[31:0] == 32'hffff_ffff && sourceOperandB[31:0] == 32'h0000_0002)
    |-> ##3 (lowResult_q == 64'h0000_0000_0000_0002 && highResult_q == 64'hffff_ffff_ffff_fffe))
    else $error("unsigned multiply-subtract result wrong");
  a_no_gpr_write: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL7]
    (state_q == SUBT) |-> !gprWriteEn)
    else $error("multiply-subtract wrote a general register");
  a_decode_start: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL8]
    (instrValid && !busy && instrWord[31:26] == 6'h1c && instrWord[15:6] == 10'h0
     && instrWord[5:0] == 6'h05) |=> (state_q == MULT))
    else $error("unsigned multiply-subtract not decoded");
  a_move_high: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL10]
    (accept && isMoveHigh) |=> (highResult_q == $past(sourceOperandA) && $stable(lowResult_q)))
    else $error("move-to-high wrong");
  a_move_low: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL11]
    (accept && isMoveLow) |=> (lowResult_q == $past(sourceOperandA)))
    else $error("move-to-low wrong");
  a_read_stall: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL17]
    (accept && (isMulSubSigned || isMulSubUnsigned))
    |=> (busy && (readStall == (readHighReq || readLowReq))) [*2] ##1 !busy)
    else $error("read not stalled during update");

  // signed form starts the pipeline as well
  a_signed_decode: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL9]
    (instrValid && !busy && instrWord[31:26] == 6'h1c && instrWord[15:6] == 10'h0
     && instrWord[5:0] == 6'h04) |=> (state_q == MULT))
    else $error("signed multiply-subtract not decoded");

  // a nonzero middle field is not a multiply-subtract
  a_bad_field: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL8]
    (instrValid && !busy && instrWord[31:26] == 6'h1c && instrWord[15:6] != 10'h0)
    |=> !busy)
    else $error("malformed word started the pipeline");

  // product stage for the unsigned form uses zero-extended words
  a_unsigned_widen: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL5]
    (accept && isMulSubUnsigned) |=> (product_q == {32'h0000_0000, $past(sourceOperandA[31:0])}
                                                   * {32'h0000_0000, $past(sourceOperandB[31:0])}))
    else $error("unsigned product wrong");

  // product stage for the signed form uses sign-extended words
  a_signed_widen: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL1]
    (accept && isMulSubSigned)
    |=> (product_q == {{32{$past(sourceOperandA[31])}}, $past(sourceOperandA[31:0])}
                      * {{32{$past(sourceOperandB[31])}}, $past(sourceOperandB[31:0])}))
    else $error("signed product wrong");

  // minuend is captured from the low words of the pair at the taking edge
  a_accum_capture: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL2]
    (accept && (isMulSubSigned || isMulSubUnsigned))
    |=> (accum_q == {$past(highResult_q[31:0]), $past(lowResult_q[31:0])}))
    else $error("minuend not captured");

  // move-to-low leaves high as it was
  a_move_low_keep: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL14]
    (accept && isMoveLow) |=> $stable(highResult_q))
    else $error("move-to-low disturbed high");

  // once idle, reads go straight through
  a_idle_no_stall: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL15]
    !busy |-> !readStall)
    else $error("read stalled while idle");

  // a write to the pair happens only through the subtract stage or a move
  a_pair_quiet: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL7]
    (state_q != SUBT && !(accept && (isMoveHigh || isMoveLow)))
    |=> ($stable(highResult_q) && $stable(lowResult_q)))
    else $error("high/low changed without a write");

  // a word offered while busy must not disturb the pending operation
  a_busy_refuse: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL17]
    (busy && instrValid)
    |=> ($stable(accum_q) && $stable(product_q)))
    else $error("word taken while busy");
endmodule : hilo_multiply_subtract_unit
`default_nettype wire

// ==== hw/hilo_mul_sub_signed_pkg.sv ====
// hilo_mul_sub_signed_pkg: constants shared by the high/low multiply-subtract unit.
// assumes a 64-bit core with 32-bit instruction words.
`default_nettype none
package hilo_mul_sub_signed_pkg;
  localparam int DataWidth = 64;
  localparam int InstrWidth = 32;
  localparam logic [5:0] OpcodeGroupTwo = 6'h1c;
  localparam logic [5:0] OpcodeSpecial = 6'h00;
  localparam logic [5:0] FuncMulSubSigned = 6'h04;
  localparam logic [5:0] FuncMulSubUnsigned = 6'h05;
  localparam logic [5:0] FuncMoveToHigh = 6'h11;
  localparam logic [5:0] FuncMoveToLow = 6'h13;
  localparam int OpcodeLsb = 26;
  localparam int ZeroFieldMsb = 15;
  localparam int ZeroFieldLsb = 6;
  localparam int MoveZeroMsb = 20;
  localparam int MulLatency = 2;
  localparam logic [63:0] HiloReset = 64'h0;
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    MULT = 2'b01,
    SUBT = 2'b10
  } mul_sub_signed_state_type;
endpackage : hilo_mul_sub_signed_pkg
`default_nettype wire

// ==== tb/pipe_issue_model.sv ====
// pipe_issue_model: stands in for the decode stage that feeds the unit.
// assumes the bench changes its controls just after falling edges.
`default_nettype none
module pipe_issue_model (
  input wire logic issue,
  input wire logic wordOp,
  input wire logic [31:0] word,
  input wire logic [63:0] opA,
  input wire logic [63:0] opB,
  output logic instrValid,
  output logic [31:0] instrWord,
  output logic [63:0] sourceOperandA,
  output logic [63:0] sourceOperandB
);
  timeunit 1ns;
  timeprecision 1ns;
  // word operands leave as proper sign-extended words; idle lines show garbage
  always_comb begin
    instrValid = issue;
    instrWord = issue ? word : ~word;
    sourceOperandA = !issue ? ~opA : wordOp ? {{32{opA[31]}}, opA[31:0]} : opA;
    sourceOperandB = !issue ? ~opB : wordOp ? {{32{opB[31]}}, opB[31:0]} : opB;
  end
endmodule : pipe_issue_model
`default_nettype wire

// ==== tb/hilo_multiply_subtract_unit_test.sv ====
// hilo_multiply_subtract_unit_test: directed bench for the high/low unit.
// assumes pipe_issue_model and the unit package are compiled first.
`default_nettype none
module hilo_multiply_subtract_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import hilo_mul_sub_signed_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, issue = 1'b0, wordOp = 1'b0, readHighReq = 1'b0, readLowReq = 1'b0;
  logic [31:0] word = 32'h0;
  logic [63:0] opA = 64'h0, opB = 64'h0, expHi = 64'h0, expLo = 64'h0;
  logic instrValid, busy, readStall, arithException, gprWriteEn;
  logic [31:0] instrWord;
  logic [63:0] sourceOperandA, sourceOperandB, highResult, lowResult;
  int n_fail = 0, samples_checked = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  pipe_issue_model pipe_u (.issue(issue), .wordOp(wordOp), .word(word), .opA(opA), .opB(opB),
    .instrValid(instrValid), .instrWord(instrWord), .sourceOperandA(sourceOperandA), .sourceOperandB(sourceOperandB));
  hilo_multiply_subtract_unit dut_u (.ref_clk(ref_clk), .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord),
    .sourceOperandA(sourceOperandA), .sourceOperandB(sourceOperandB), .readHighReq(readHighReq),
    .readLowReq(readLowReq), .busy(busy), .readStall(readStall), .arithException(arithException),
    .gprWriteEn(gprWriteEn), .highResult(highResult), .lowResult(lowResult));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 2000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // one word held for one cycle; returns at the falling edge after the taking edge
  task automatic send(input logic [31:0] w, input logic wo, input logic [63:0] a, input logic [63:0] b);
    @(negedge ref_clk);
    {issue, wordOp, word, opA, opB} = {1'b1, wo, w, a, b};
    @(negedge ref_clk);
    issue = 1'b0;
  endtask : send
  task automatic move_case(input logic toHigh, input logic [63:0] v);
    readLowReq = 1'b1;
    send({6'h00, 5'd1, 15'h0, toHigh ? FuncMoveToHigh : FuncMoveToLow}, 1'b0, v, ~v);
    chk("stall", 64'h0, {63'h0, readStall});
    readLowReq = 1'b0;
    if (toHigh) expHi = v;
    else expLo = v;
    chk("high", expHi, highResult);
    chk("low", expLo, lowResult);
    $display("move test done");
  endtask : move_case
  task automatic mul_sub_signed_case(input logic uns, input logic [63:0] a, input logic [63:0] b);
    logic [63:0] prod;
    logic [63:0] diff;
    if (uns) prod = {32'h0, a[31:0]} * {32'h0, b[31:0]};
    else prod = 64'($signed(a[31:0])) * 64'($signed(b[31:0]));
    diff = {expHi[31:0], expLo[31:0]} - prod;
    send({6'h1c, 5'd1, 5'd2, 10'h0, uns ? FuncMulSubUnsigned : FuncMulSubSigned}, 1'b1, a, b);
    readHighReq = 1'b1;
    #1 chk("stall", 64'h1, {63'h0, readStall});
    @(negedge ref_clk);
    chk("busy", 64'h1, {63'h0, busy});
    @(negedge ref_clk);
    expHi = {{32{diff[63]}}, diff[63:32]};
    expLo = {{32{diff[31]}}, diff[31:0]};
    chk("busy", 64'h0, {63'h0, busy});
    chk("high", expHi, highResult);
    chk("low", expLo, lowResult);
    chk("flags", 64'h0, {62'h0, arithException, gprWriteEn});
    chk("stall", 64'h0, {63'h0, readStall});
    @(negedge ref_clk);
    readHighReq = 1'b0;
    $display("mul_sub_signed test done");
  endtask : mul_sub_signed_case
  // mid-run reset: pair back to zero, nothing pending
  task automatic reset_case;
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    expHi = 64'h0;
    expLo = 64'h0;
    chk("reset high", 64'h0, highResult);
    chk("reset low", 64'h0, lowResult);
    chk("reset busy", 64'h0, {63'h0, busy});
    nrst = 1'b1;
    $display("reset test done");
  endtask : reset_case
  initial begin
    repeat (4) @(negedge ref_clk);
    chk("reset", 64'h0, highResult | lowResult);
    nrst = 1'b1;
    move_case(1'b1, 64'hffff_ffff_8000_0001);
    move_case(1'b0, 64'h0000_0000_7fff_fffe);
    mul_sub_signed_case(1'b0, 64'hffff_ffff_ffff_fffd, 64'h5);
    mul_sub_signed_case(1'b1, 64'hffff_ffff_ffff_ffff, 64'h2);
    mul_sub_signed_case(1'b0, 64'h7fff_ffff, 64'hffff_ffff_8000_0000);
    // nonzero middle field must not be taken as a multiply-subtract
    send({6'h1c, 5'd1, 5'd2, 10'h040, FuncMulSubSigned}, 1'b1, 64'h3, 64'h3);
    repeat (3) @(negedge ref_clk);
    chk("high", expHi, highResult);
    chk("low", expLo, lowResult);
    $display("decode test done");
    reset_case();
    mul_sub_signed_case(1'b0, 64'hffff_ffff_ffff_ffff, 64'h2);
    move_case(1'b1, 64'h0);
    move_case(1'b0, 64'h0);
    mul_sub_signed_case(1'b1, 64'hffff_ffff_ffff_ffff, 64'h2);
    report_and_stop();
  end
endmodule : hilo_multiply_subtract_unit_test
`default_nettype wire
